// [core/capture_edge_sync.sv]
// pin synchroniser with agreement filter and valid-edge detection
`timescale 1ns/1ns
`default_nettype none
module capture_edge_sync (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pinIn,
  input wire logic [1:0] edgeSel,
  output logic validEdge
);

  logic syncA;
  logic syncB;
  logic syncC;
  logic level;
  logic rise;
  logic fall;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
      syncC <= 1'b0;
    end else begin
      syncA <= pinIn;
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  // a change counts only once two later stages agree
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= 1'b0;
    end else if (syncB == syncC) begin
      level <= syncC;
    end
  end

  assign rise = (syncB == syncC) && syncC && !level;
  assign fall = (syncB == syncC) && !syncC && level;

  always_comb begin
    if (edgeSel == timer_pkg::EDGE_RISE) begin
      validEdge = rise;
    end else if (edgeSel == timer_pkg::EDGE_FALL) begin
      validEdge = fall;
    end else if (edgeSel == timer_pkg::EDGE_BOTH) begin
      validEdge = rise || fall;
    end else begin
      validEdge = 1'b0;
    end
  end

endmodule
`default_nettype wire

// [core/tick_divider.sv]
// count clock prescaler producing a one-cycle tick
`timescale 1ns/1ns
`default_nettype none
module tick_divider (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [2:0] divSel,
  output logic tick
);

  logic [timer_pkg::PRESC_CNT_W-1:0] divCount;
  logic [timer_pkg::PRESC_CNT_W-1:0] divLast;

  // divide by two to the power of divSel
  assign divLast = timer_pkg::PRESC_CNT_W'((8'h01 << divSel) - 8'h01);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      divCount <= '0;
      tick <= 1'b0;
    end else if (!enable) begin
      divCount <= '0;
      tick <= 1'b0;
    end else if (divCount >= divLast) begin
      divCount <= '0;
      tick <= 1'b1;
    end else begin
      divCount <= divCount + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [core/timer_pkg.sv]
// constants and types shared by the timer channel-0 block
package timer_pkg;

  localparam int DATA_W = 32;
  localparam int CNT_W = 16;

  // register indices; byte address is four times the index
  localparam logic [31:0] CTRL_INDEX = 32'hFFFFF540;
  localparam logic [31:0] OPT_INDEX = 32'hFFFFF545;
  localparam logic [31:0] CHAN0_SHADOW_BUFFER_INDEX = 32'hFFFFF546;

  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_W = 3;
  localparam int CTRL_OUTEN_BIT = 4;
  localparam int CTRL_RUN_BIT = 7;
  localparam int CTRL_EDGE_LSB = 8;
  localparam int CTRL_EDGE_W = 2;
  localparam int CTRL_PRESC_LSB = 10;
  localparam int CTRL_PRESC_W = 3;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_MASK = 16'h1F97;

  // option register fields
  localparam int OPT_WRAP_BIT = 0;
  localparam int OPT_CCS0_BIT = 4;

  localparam logic [15:0] CHAN0_SHADOW_BUFFER_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  // capture edge selection codes
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  localparam int PRESC_CNT_W = 7;

  typedef enum logic [2:0] {
    MODE_INTERVAL,
    MODE_EVENT_COUNT,
    MODE_EXT_TRIGGER,
    MODE_ONE_SHOT,
    MODE_PWM,
    MODE_FREE_RUN,
    MODE_PULSE_WIDTH,
    MODE_TRI_PWM
  } timer_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  function automatic logic [31:0] index_to_addr(input logic [31:0] idx);
    return {idx[29:0], 2'h0};
  endfunction

endpackage

// [core/timer_unit_cc0.sv]
// timer counter with overflow flag and channel-0 capture/compare
//
// Contract
// - wrap flag sets on wrap, free-run/pulse-width
// - flag clears on zero write or stop
// - wrap irq pulses with flag set
// - no wrap irq in other modes
// - reading leaves wrap flag unchanged
// - writing one to flag does nothing
// - free-run: select bit picks capture/compare
// - pulse-width mode: capture only
// - other modes: compare only
// - channel-0 accessible while running, 16-bit
// - channel-0 register resets to zero
// - compare writes allowed running, feed shadow
// - counter equals shadow raises match irq
// - match toggles output pin when enabled
// - cycle modes clear counter on match
// - free-run capture copies counter on edge
// - pulse-width capture stores and clears counter
// - capture during read returns coherent value
// - anytime or batch writes per mode
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module timer_unit_cc0 (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire timer_pkg::apb_req_t apbReq,
  output timer_pkg::apb_rsp_t apbRsp,
  input wire logic captureInPin0,
  output logic timerOutPin0,
  output logic wrapIrq,
  output logic chan0MatchIrq
);

  logic [15:0] timerControlReg;
  logic counterWrapFlag;
  logic chan0CaptureSelect;
  logic [15:0] channel0CaptureCompare;
  logic [15:0] chan0ShadowBuffer;
  logic [15:0] counter;

  logic pready;
  logic pslverr;
  logic [31:0] prdata;

  logic countRunBit;
  logic outputEnable;
  logic [1:0] edgeSel;
  logic [2:0] prescSel;
  timer_pkg::timer_mode_t mode;

  logic countTick;
  logic captureEdge;
  logic stepTick;

  logic accessPhase;
  logic writeDone;
  logic hitCtrl;
  logic hitOpt;
  logic hitCcr0;
  logic hitAny;

  logic wrapMode;
  logic captureRole;
  logic cycleMode;
  logic batchMode;
  logic atMax;
  logic matchHit;
  logic wrapEvent;
  logic captureHit;

  logic [15:0] optionValue;
  logic [15:0] readValue;
  logic [15:0] next_shadow;

  // control field decode
  assign countRunBit = timerControlReg[timer_pkg::CTRL_RUN_BIT];
  assign outputEnable = timerControlReg[timer_pkg::CTRL_OUTEN_BIT];
  assign edgeSel = timerControlReg[timer_pkg::CTRL_EDGE_LSB +: timer_pkg::CTRL_EDGE_W];
  assign prescSel = timerControlReg[timer_pkg::CTRL_PRESC_LSB +: timer_pkg::CTRL_PRESC_W];
  assign mode = timer_pkg::timer_mode_t'(
    timerControlReg[timer_pkg::CTRL_MODE_LSB +: timer_pkg::CTRL_MODE_W]);

  tick_divider u_divider (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(countRunBit),
    .divSel(prescSel),
    .tick(countTick)
  );

  capture_edge_sync u_capture (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pinIn(captureInPin0),
    .edgeSel(edgeSel),
    .validEdge(captureEdge)
  );

  // mode classification
  assign wrapMode = (mode == timer_pkg::MODE_FREE_RUN) ||
                    (mode == timer_pkg::MODE_PULSE_WIDTH);

  always_comb begin
    case (mode)
      timer_pkg::MODE_FREE_RUN: begin
        captureRole = chan0CaptureSelect;
      end
      timer_pkg::MODE_PULSE_WIDTH: begin
        captureRole = 1'b1;
      end
      default: begin
        captureRole = 1'b0;
      end
    endcase
  end

  always_comb begin
    case (mode)
      timer_pkg::MODE_EXT_TRIGGER,
      timer_pkg::MODE_PWM,
      timer_pkg::MODE_TRI_PWM: begin
        batchMode = 1'b1;
      end
      default: begin
        batchMode = 1'b0;
      end
    endcase
  end

  assign cycleMode = !wrapMode;

  // event counter advances on pin edges, the rest on the prescaler
  assign stepTick = (mode == timer_pkg::MODE_EVENT_COUNT) ?
                    (countRunBit && captureEdge) : countTick;

  assign atMax = (counter == timer_pkg::CNT_MAX);
  assign matchHit = countRunBit && stepTick && !captureRole &&
                    (counter == chan0ShadowBuffer);
  assign wrapEvent = countRunBit && stepTick && atMax && wrapMode;
  // event-count mode uses the pin as its count source, never as capture
  assign captureHit = countRunBit && captureRole && captureEdge &&
                      (mode != timer_pkg::MODE_EVENT_COUNT);

  // bus decode
  assign accessPhase = apbReq.psel && apbReq.penable;
  assign writeDone = accessPhase && pready && apbReq.pwrite;

  always_comb begin
    hitCtrl = 1'b0;
    hitOpt = 1'b0;
    hitCcr0 = 1'b0;
    if (apbReq.paddr == timer_pkg::index_to_addr(timer_pkg::CTRL_INDEX)) begin
      hitCtrl = 1'b1;
    end else if (apbReq.paddr == timer_pkg::index_to_addr(timer_pkg::OPT_INDEX)) begin
      hitOpt = 1'b1;
    end else if (apbReq.paddr == timer_pkg::index_to_addr(timer_pkg::CHAN0_SHADOW_BUFFER_INDEX)) begin
      hitCcr0 = 1'b1;
    end
  end

  assign hitAny = hitCtrl || hitOpt || hitCcr0;

  always_comb begin
    optionValue = 16'h0000;
    optionValue[timer_pkg::OPT_WRAP_BIT] = counterWrapFlag;
    optionValue[timer_pkg::OPT_CCS0_BIT] = chan0CaptureSelect;
  end

  // one wait state: read data is a snapshot taken in one edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= accessPhase && !pready;
    end
  end

  // read mux; sampled once per access so a same-edge capture cannot tear it
  always_comb begin
    readValue = 16'h0000;
    if (apbReq.pwrite) begin
      readValue = 16'h0000;
    end else if (hitCtrl) begin
      readValue = timerControlReg;
    end else if (hitOpt) begin
      readValue = optionValue;
    end else if (hitCcr0) begin
      readValue = channel0CaptureCompare;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (accessPhase && !pready) begin
      prdata <= {16'h0000, readValue};
    end
  end

  // error stands only beside pready, never past the access
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= accessPhase && !pready && !hitAny;
    end
  end

  always_comb begin
    apbRsp.pready = pready;
    apbRsp.pslverr = pslverr;
    apbRsp.prdata = prdata;
  end

  // control register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timerControlReg <= timer_pkg::CTRL_RESET;
    end else if (writeDone && hitCtrl) begin
      timerControlReg <= apbReq.pwdata[15:0] & timer_pkg::CTRL_MASK;
    end
  end

  // capture select bit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan0CaptureSelect <= 1'b0;
    end else if (writeDone && hitOpt) begin
      chan0CaptureSelect <= apbReq.pwdata[timer_pkg::OPT_CCS0_BIT];
    end
  end

  // wrap flag: hardware set wins over any clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      counterWrapFlag <= 1'b0;
    end else if (wrapEvent) begin
      counterWrapFlag <= 1'b1;
    end else if (!countRunBit) begin
      counterWrapFlag <= 1'b0;
    end else if (writeDone && hitOpt && !apbReq.pwdata[timer_pkg::OPT_WRAP_BIT]) begin
      counterWrapFlag <= 1'b0;
    end
  end

  // irq pulses registered at the same edge as the flag
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrapIrq <= 1'b0;
    end else begin
      wrapIrq <= wrapEvent;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan0MatchIrq <= 1'b0;
    end else begin
      chan0MatchIrq <= matchHit;
    end
  end

  // output pin toggles on compare match
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timerOutPin0 <= 1'b0;
    end else if (!outputEnable) begin
      timerOutPin0 <= 1'b0;
    end else if (matchHit) begin
      timerOutPin0 <= !timerOutPin0;
    end
  end

  // counter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter <= timer_pkg::CNT_ZERO;
    end else if (!countRunBit) begin
      counter <= timer_pkg::CNT_ZERO;
    end else if (captureHit && mode == timer_pkg::MODE_PULSE_WIDTH) begin
      counter <= timer_pkg::CNT_ZERO;
    end else if (matchHit && cycleMode) begin
      counter <= timer_pkg::CNT_ZERO;
    end else if (stepTick) begin
      counter <= counter + 16'h0001;
    end
  end

  // channel-0 register: capture takes priority over a same-edge write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel0CaptureCompare <= timer_pkg::CHAN0_SHADOW_BUFFER_RESET;
    end else if (captureHit) begin
      channel0CaptureCompare <= counter;
    end else if (writeDone && hitCcr0) begin
      channel0CaptureCompare <= apbReq.pwdata[15:0];
    end
  end

  // shadow buffer load policy
  always_comb begin
    next_shadow = chan0ShadowBuffer;
    if (!countRunBit) begin
      next_shadow = channel0CaptureCompare;
    end else if (!batchMode && writeDone && hitCcr0) begin
      next_shadow = apbReq.pwdata[15:0];
    end else if (batchMode && matchHit) begin
      next_shadow = channel0CaptureCompare;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan0ShadowBuffer <= timer_pkg::CHAN0_SHADOW_BUFFER_RESET;
    end else begin
      chan0ShadowBuffer <= next_shadow;
    end
  end

endmodule
`default_nettype wire

// [tb/timer_overflow_and_cc0_channel_tb_top.sv]
// self-checking bench for the timer channel-0 block
`timescale 1ns/1ns
`default_nettype none
module timer_overflow_and_cc0_channel_tb_top;
  localparam logic [31:0] CTRL_A = {timer_pkg::CTRL_INDEX[29:0], 2'h0};
  localparam logic [31:0] OPT_A = {timer_pkg::OPT_INDEX[29:0], 2'h0};
  localparam logic [31:0] CCR_A = {timer_pkg::CHAN0_SHADOW_BUFFER_INDEX[29:0], 2'h0};
  localparam logic [2:0] MODES [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h7};
  localparam logic BATCH [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  timer_pkg::apb_req_t apbReq = '0;
  timer_pkg::apb_rsp_t apbRsp;
  logic captureInPin0;
  logic timerOutPin0;
  logic wrapIrq;
  logic chan0MatchIrq;
  logic [15:0] flips;
  int mismatches = 0;
  int comparisons = 0;
  always #50 core_clk = ~core_clk;
  timer_unit_cc0 timer_unit_cc0_i (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .apbReq(apbReq),
    .apbRsp(apbRsp),
    .captureInPin0(captureInPin0),
    .timerOutPin0(timerOutPin0),
    .wrapIrq(wrapIrq),
    .chan0MatchIrq(chan0MatchIrq)
  );
  timer_pin_model timer_pin_model_i (
    .core_clk(core_clk),
    .timerOutPin0(timerOutPin0),
    .captureInPin0(captureInPin0),
    .flips(flips)
  );
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request stands until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
    int n;
    n = 0;
    @(posedge core_clk);
    apbReq.psel <= 1'b1;
    apbReq.pwrite <= wr;
    apbReq.paddr <= a;
    apbReq.pwdata <= d;
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 20);
    chk("pready", 32'h1, {31'h0, apbRsp.pready});
    q = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    logic [31:0] q;
    logic err;
    apb(1'b1, a, {16'h0000, d}, q, err);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] q);
    logic err;
    apb(1'b0, a, 32'h0, q, err);
  endtask
  task automatic wait_match(output int c);
    c = 0;
    do begin
      @(negedge core_clk);
      c++;
    end while (chan0MatchIrq !== 1'b1 && c < 1000);
  endtask
  task automatic reset_values();
    logic [31:0] q;
    logic err;
    rd(CCR_A, q);
    chk("chan0_shadow_buffer reset", 32'h0, q);
    apb(1'b0, 32'h00000000, 32'h0, q, err);
    chk("unmapped err", 32'h1, {31'h0, err});
  endtask
  task automatic compare_mode(input logic [2:0] mode, input logic batch);
    int c;
    logic [15:0] f;
    wr(CTRL_A, 16'h0000);
    wr(CCR_A, 16'h0009);
    wr(CTRL_A, 16'h0090 | {13'h0, mode});
    wait_match(c);
    f = flips;
    wait_match(c);
    chk("cycle period", 32'hA, c);
    chk("pin flips", {16'h0, f + 16'h1}, {16'h0, flips});
    wr(CCR_A, 16'h0031);
    wait_match(c);
    chk("old cycle kept", {31'h0, batch}, {31'h0, c <= 10});
    wait_match(c);
    chk("new period", 32'h32, c);
    wr(CTRL_A, 16'h0000);
  endtask
  task automatic event_count();
    logic [15:0] f;
    wr(CTRL_A, 16'h0000);
    wr(CCR_A, 16'h0002);
    wr(CTRL_A, 16'h0091);
    f = flips;
    repeat (3) begin
      timer_pin_model_i.pulse(4);
      repeat (4) @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
    chk("event match flips", {16'h0, f + 16'h1}, {16'h0, flips});
    wr(CTRL_A, 16'h0000);
  endtask
  task automatic free_run_capture();
    logic [31:0] a;
    logic [31:0] b;
    wr(OPT_A, 16'h0010);
    wr(CTRL_A, 16'h0285);
    fork
      timer_pin_model_i.pulse(40);
      begin
        repeat (20) @(posedge core_clk);
        rd(CCR_A, a);
      end
    join
    repeat (10) @(posedge core_clk);
    rd(CCR_A, b);
    chk("capture span", 32'h28, b - a);
    wr(CTRL_A, 16'h0000);
  endtask
  task automatic pulse_width_capture();
    logic [31:0] a;
    logic [31:0] b;
    wr(OPT_A, 16'h0000);
    wr(CTRL_A, 16'h0286);
    timer_pin_model_i.pulse(30);
    repeat (30) @(posedge core_clk);
    fork
      timer_pin_model_i.pulse(30);
      begin
        repeat (20) @(posedge core_clk);
        rd(CCR_A, a);
      end
    join
    repeat (10) @(posedge core_clk);
    rd(CCR_A, b);
    // one cycle of slack: the clear and the store share an edge
    chk("low width", 32'h1, {31'h0, a == 32'h1E || a == 32'h1D});
    chk("high width", 32'h1, {31'h0, b == 32'h1E || b == 32'h1D});
    wr(CTRL_A, 16'h0000);
  endtask
  task automatic wrap_flag();
    logic [31:0] q;
    int c;
    wr(CTRL_A, 16'h0085);
    c = 0;
    do begin
      @(negedge core_clk);
      c++;
    end while (wrapIrq !== 1'b1 && c < 70000);
    chk("wrap irq", 32'h1, {31'h0, wrapIrq});
    rd(OPT_A, q);
    chk("flag set", 32'h1, q & 32'h1);
    rd(OPT_A, q);
    chk("flag kept", 32'h1, q & 32'h1);
    wr(OPT_A, 16'h0001);
    rd(OPT_A, q);
    chk("flag kept on one", 32'h1, q & 32'h1);
    wr(OPT_A, 16'h0000);
    rd(OPT_A, q);
    chk("flag cleared", 32'h0, q & 32'h1);
    wr(OPT_A, 16'h0001);
    rd(OPT_A, q);
    chk("flag not settable", 32'h0, q & 32'h1);
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    reset_values();
    for (int i = 0; i < 5; i++) begin
      compare_mode(MODES[i], BATCH[i]);
    end
    event_count();
    free_run_capture();
    pulse_width_capture();
    wrap_flag();
    tally_and_finish();
  end
  // one wrap takes 65536 cycles; everything else is under a thousand
  initial begin
    repeat (90000) @(posedge core_clk);
    mismatches++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// [tb/timer_pin_model.sv]
// capture pin driver and output pin watcher
`timescale 1ns/1ns
`default_nettype none
module timer_pin_model (
  input wire logic core_clk,
  input wire logic timerOutPin0,
  output logic captureInPin0,
  output logic [15:0] flips
);
  logic lastOut = 1'b0;
  initial captureInPin0 = 1'b0;
  initial flips = 16'h0000;
  // callers keep widths of 2 cycles or more, else the pin filter drops them
  task automatic pulse(input int w);
    captureInPin0 <= 1'b1;
    repeat (w) @(posedge core_clk);
    captureInPin0 <= 1'b0;
  endtask
  always @(posedge core_clk) begin
    lastOut <= timerOutPin0;
    if (timerOutPin0 !== lastOut) begin
      flips <= flips + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// [tb/timer_unit_cc0_props.sv]
// port checker for the timer channel-0 block
`timescale 1ns/1ns
`default_nettype none
module timer_unit_cc0_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire timer_pkg::apb_req_t apbReq,
  input wire timer_pkg::apb_rsp_t apbRsp,
  input wire logic captureInPin0,
  input wire logic timerOutPin0,
  input wire logic wrapIrq,
  input wire logic chan0MatchIrq
);
  localparam logic [31:0] CTRL_A = {timer_pkg::CTRL_INDEX[29:0], 2'h0};
  logic [15:0] ctrl;
  logic [2:0] mode;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // mirror of the control register so mode-dependent checks know the mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= 16'h0000;
    end else if (apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite
        && apbReq.paddr == CTRL_A) begin
      ctrl <= apbReq.pwdata[15:0];
    end
  end
  assign mode = ctrl[2:0];
  ready_wait_a: assert property (apbReq.psel && $rose(apbReq.penable) |=> apbRsp.pready)
    else $error("pready late");
  ready_pulse_a: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("pready held");
  err_ready_a: assert property (apbRsp.pslverr |-> apbRsp.pready)
    else $error("pslverr alone");
  upper_zero_a: assert property (apbRsp.pready |-> apbRsp.prdata[31:16] == 16'h0000)
    else $error("upper data set");
  wrap_mode_a: assert property (wrapIrq |-> mode == 3'h5 || mode == 3'h6)
    else $error("wrap irq in wrong mode");
  wrap_pulse_a: assert property (wrapIrq |=> !wrapIrq)
    else $error("wrap irq held");
  no_match_pw_a: assert property (mode == 3'h6 && $stable(mode) |-> !chan0MatchIrq)
    else $error("match in capture mode");
  idle_quiet_a: assert property (!ctrl[7] && !$past(ctrl[7]) |-> !chan0MatchIrq && !wrapIrq)
    else $error("irq while stopped");
  out_off_a: assert property (!ctrl[4] && !$past(ctrl[4]) |-> !timerOutPin0)
    else $error("pin driven while off");
  pin_flip_a: assert property ($changed(timerOutPin0) && ctrl[4] && $past(ctrl[4]) && ctrl[7]
      && $past(ctrl[7]) |-> chan0MatchIrq || $past(chan0MatchIrq))
    else $error("pin flip without match");
endmodule
bind timer_unit_cc0 timer_unit_cc0_props timer_unit_cc0_props_i (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .apbReq(apbReq),
  .apbRsp(apbRsp),
  .captureInPin0(captureInPin0),
  .timerOutPin0(timerOutPin0),
  .wrapIrq(wrapIrq),
  .chan0MatchIrq(chan0MatchIrq)
);
`default_nettype wire
